// ===== tebis_pkg.sv
// Constants shared by the touch event buffer and its I2C slave read port.
// Assumes a single 50 MHz system clock; no software-visible registers.
//
// Operation
// - Queue generated packets first-in first-out; interrupt asserted while any packet waits.
// - Interrupt output is active low and always driven high or low.
// - Interrupt releases once every queued packet has been fully sent.
// - Stay-active output held while any packet remains queued.
// - Pop a packet only when its last byte has been shifted out.
// - A partly read packet stays queued and is sent again next read.
// - In operational mode, read address is not acknowledged while queue is empty.
// - Stop before third byte returns slave to idle; next read restarts the packet.
// - Queue holds 22 packets; a push when full discards the oldest.
// - Packets generated only once per sample period, at most 12 per period.
// - Every byte is shifted out most significant bit first.
// - Read sends counter/type byte, then description high, then description low.
// - Upper nibble of byte 1 is a counter incremented per event, wrapping after 15.
// - Lower nibble of byte 1 carries the event type code.
// - Type codes: 0 touch, 1 release, 2 slider.
// - Touch or release description byte holds the sensing input index 0 to 11.
// - Slider packet carries position 0 to 0xFFFE, high byte first.
// - Slider release queues one final slider packet holding 0xFFFF.
// - Each qualified event produces one packet, up to 12 per period; events past the twelfth produce none.
// - Slave address comes from a stored configuration value input.
package tebis_pkg;
  localparam int          QUEUE_DEPTH     = 22;
  localparam int          MAX_PER_PERIOD  = 12;
  localparam int          NUM_INPUTS      = 12;
  localparam int          PKT_WIDTH       = 24;
  localparam int          CNT_MSB         = 23;
  localparam int          CNT_LSB         = 20;
  localparam int          TYPE_MSB        = 19;
  localparam int          TYPE_LSB        = 16;
  localparam logic [3:0]  TYPE_TOUCH      = 4'h0;
  localparam logic [3:0]  TYPE_RELEASE    = 4'h1;
  localparam logic [3:0]  TYPE_SLIDER     = 4'h2;
  localparam logic [15:0] SLIDER_POS_MAX  = 16'hFFFE;
  localparam logic [15:0] SLIDER_RELEASED = 16'hFFFF;
  localparam logic [7:0]  DESC_UNUSED     = 8'h00;
  localparam logic [7:0]  IDLE_BYTE       = 8'hFF;
  localparam logic [3:0]  CNT_RESET       = 4'h0;
  localparam logic [1:0]  BYTE_LAST       = 2'h2;
  localparam logic [2:0]  BIT_LAST        = 3'h7;

  typedef enum logic [2:0] {
    TEBIS_IDLE  = 3'b000,
    TEBIS_ADDR  = 3'b001,
    TEBIS_AACK  = 3'b010,
    TEBIS_TX    = 3'b011,
    TEBIS_MACK  = 3'b100,
    TEBIS_WAIT  = 3'b101
  } tebis_state_t;
endpackage : tebis_pkg

// ===== tebis_mem_if.sv
// Carrier between the queue control logic and its packet memory.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface tebis_mem_if #(
  parameter int WIDTH = 24,
  parameter int AW    = 5
);
  logic             wr_en;
  logic [AW-1:0]    wr_addr;
  logic [WIDTH-1:0] wr_data;
  logic [AW-1:0]    rd_addr;
  logic [WIDTH-1:0] rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : tebis_mem_if

// ===== tebis_mem.sv
// Packet store of the event queue: one write port, registered read port.
// Assumes the controller keeps addresses below DEPTH.
`timescale 1ns/1ps
module tebis_mem #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 22,
  parameter int AW    = 5
) (
  input  wire logic  clk_sys,
  tebis_mem_if.mem   port
);
  logic [WIDTH-1:0] store [DEPTH];

  // Refuse an address width too narrow for the depth
  if (DEPTH < 1 || AW < $clog2(DEPTH)) begin : g_bad_aw
    $error("AW too narrow for DEPTH");
  end

  // Write on request, read data always registered
  always_ff @(posedge clk_sys) begin
    if (port.wr_en) begin
      store[port.wr_addr] <= port.wr_data;
    end
    port.rd_data <= store[port.rd_addr];
  end
endmodule : tebis_mem

// ===== tebis_top.sv
// Touch event queue with I2C slave read-out and active-low event interrupt.
// Assumes events arrive synchronous to clk_sys; I2C pins are asynchronous.
`timescale 1ns/1ps
module tebis_top #(
  parameter int DEPTH   = tebis_pkg::QUEUE_DEPTH,
  parameter int MAX_GEN = tebis_pkg::MAX_PER_PERIOD
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [6:0]  slave_addr,
  input  wire logic        operational,
  input  wire logic        sample_tick,
  input  wire logic [11:0] touch_evt,
  input  wire logic [11:0] release_evt,
  input  wire logic        slider_evt,
  input  wire logic [15:0] slider_pos,
  input  wire logic        slider_rel,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             event_int_n,
  output logic             stay_active,
  output logic             overflow
);
  localparam int AW = $clog2(DEPTH);

  // Refuse shapes the pointer logic cannot serve
  if (DEPTH < 2 || DEPTH > 255) begin : g_bad_depth
    $error("DEPTH must lie between 2 and 255");
  end
  if (MAX_GEN < 1 || MAX_GEN > 15) begin : g_bad_gen
    $error("MAX_GEN must lie between 1 and 15");
  end

  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [3:0]    GEN_MAX  = 4'(MAX_GEN);

  tebis_mem_if #(.WIDTH(tebis_pkg::PKT_WIDTH), .AW(AW)) mif ();

  tebis_mem #(.WIDTH(tebis_pkg::PKT_WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk_sys (clk_sys),
    .port    (mif.mem)
  );

  // ------------------------------------------------------------
  // Event capture and packet generation
  // ------------------------------------------------------------
  logic [11:0] pend_touch_reg;
  logic [11:0] pend_rel_reg;
  logic        pend_sl_reg;
  logic        pend_slr_reg;
  logic [15:0] sl_pos_reg;
  logic [3:0]  gen_cnt_reg;
  logic [3:0]  seq_cnt_reg;

  // Lowest pending input index
  function automatic logic [3:0] low_index(input logic [11:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 11; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : low_index

  wire         gen_room   = (gen_cnt_reg < GEN_MAX);
  wire         has_touch  = |pend_touch_reg;
  wire         has_rel    = |pend_rel_reg;
  wire         gen_any    = has_touch | has_rel | pend_sl_reg | pend_slr_reg;
  wire         gen_push   = gen_any & gen_room;
  wire [3:0]   touch_idx  = low_index(pend_touch_reg);
  wire [3:0]   rel_idx    = low_index(pend_rel_reg);
  wire [15:0]  sl_clamped = (sl_pos_reg > tebis_pkg::SLIDER_POS_MAX) ? tebis_pkg::SLIDER_POS_MAX : sl_pos_reg;

  // Packet selection: touches, then releases, then slider position, then slider release
  wire [3:0]   pkt_type = has_touch   ? tebis_pkg::TYPE_TOUCH :
                          has_rel     ? tebis_pkg::TYPE_RELEASE :
                                        tebis_pkg::TYPE_SLIDER;
  wire [15:0]  pkt_desc = has_touch   ? {4'h0, touch_idx, tebis_pkg::DESC_UNUSED} :
                          has_rel     ? {4'h0, rel_idx, tebis_pkg::DESC_UNUSED} :
                          pend_sl_reg ? sl_clamped :
                                        tebis_pkg::SLIDER_RELEASED;
  wire [23:0]  pkt_word = {seq_cnt_reg, pkt_type, pkt_desc};

  wire [11:0]  touch_clr = has_touch ? (12'h001 << touch_idx) : 12'h000;
  wire [11:0]  rel_clr   = (!has_touch && has_rel) ? (12'h001 << rel_idx) : 12'h000;
  wire         sl_clr    = !has_touch && !has_rel && pend_sl_reg;
  wire         slr_clr   = !has_touch && !has_rel && !pend_sl_reg && pend_slr_reg;

  // Events latched once per sample period, one packet emitted per cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pend_touch_reg <= 12'h000;
      pend_rel_reg   <= 12'h000;
      pend_sl_reg    <= 1'b0;
      pend_slr_reg   <= 1'b0;
      sl_pos_reg     <= 16'h0000;
      gen_cnt_reg    <= 4'h0;
    end else if (sample_tick) begin
      pend_touch_reg <= touch_evt;
      pend_rel_reg   <= release_evt;
      pend_sl_reg    <= slider_evt;
      pend_slr_reg   <= slider_rel;
      sl_pos_reg     <= slider_pos;
      gen_cnt_reg    <= 4'h0;
    end else if (gen_push) begin
      pend_touch_reg <= pend_touch_reg & ~touch_clr;
      pend_rel_reg   <= pend_rel_reg & ~rel_clr;
      pend_sl_reg    <= pend_sl_reg & ~sl_clr;
      pend_slr_reg   <= pend_slr_reg & ~slr_clr;
      gen_cnt_reg    <= gen_cnt_reg + 4'h1;
    end
  end

  // Sequence counter wraps from 15 to 0 by its width
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      seq_cnt_reg <= tebis_pkg::CNT_RESET;
    end else if (gen_push) begin
      seq_cnt_reg <= seq_cnt_reg + 4'h1;
    end
  end

  // ------------------------------------------------------------
  // Queue pointers
  // ------------------------------------------------------------
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic          pop_req;
  logic          head_lost_reg;
  logic          tx_active;

  wire           q_empty   = (count_reg == '0);
  wire           q_full    = (count_reg == CNT_FULL);
  wire           drop_old  = gen_push & q_full;
  wire           do_pop    = pop_req & !q_empty & !head_lost_reg & !drop_old;
  wire [AW-1:0]  wr_ptr_nx = (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
  wire [AW-1:0]  rd_ptr_nx = (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;

  assign mif.wr_en   = gen_push;
  assign mif.wr_addr = wr_ptr_reg;
  assign mif.wr_data = pkt_word;
  assign mif.rd_addr = rd_ptr_reg;

  // Write pointer, read pointer and fill count; a full push advances the head
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (gen_push) begin
        wr_ptr_reg <= wr_ptr_nx;
      end
      if (drop_old || do_pop) begin
        rd_ptr_reg <= rd_ptr_nx;
      end
      if (gen_push && !q_full && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !gen_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // A head discarded mid-transfer must not be popped again at its end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      head_lost_reg <= 1'b0;
    end else if (drop_old && tx_active && !pop_req) begin
      head_lost_reg <= 1'b1;
    end else if (!tx_active || pop_req) begin
      head_lost_reg <= 1'b0; // Only the lost packet's completion is skipped
    end
  end

  // Interrupt and wake hold follow queue occupancy
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      event_int_n <= 1'b1;
      stay_active <= 1'b0;
      overflow    <= 1'b0;
    end else begin
      event_int_n <= q_empty;
      stay_active <= !q_empty;
      overflow    <= drop_old;
    end
  end

  // ------------------------------------------------------------
  // I2C slave transmitter
  // ------------------------------------------------------------
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;

  // Two-stage synchronisers, then one history stage for edges
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end

  wire scl_s    = scl_sync_reg[1];
  wire sda_s    = sda_sync_reg[1];
  wire scl_rise = scl_s & !scl_d_reg;
  wire scl_fall = !scl_s & scl_d_reg;
  wire start_c  = scl_s & scl_d_reg & sda_d_reg & !sda_s;
  wire stop_c   = scl_s & scl_d_reg & !sda_d_reg & sda_s;

  tebis_pkg::tebis_state_t state_reg;
  tebis_pkg::tebis_state_t state_next;
  logic [7:0]  sr_reg;
  logic [2:0]  bit_reg;
  logic [1:0]  byte_reg;
  logic [23:0] word_reg;
  logic        has_pkt_reg;
  logic        ack_reg;
  logic        drive_low_reg;

  wire        addr_hit  = (sr_reg[7:1] == slave_addr) & sr_reg[0];
  wire        may_ack   = addr_hit & (!q_empty | !operational);
  wire        load_new  = (byte_reg == 2'h0);
  wire [23:0] src_word  = load_new ? mif.rd_data : word_reg;
  wire        src_valid = load_new ? !q_empty : has_pkt_reg;
  wire [7:0]  tx_byte   = !src_valid            ? tebis_pkg::IDLE_BYTE :
                          (byte_reg == 2'h0)    ? src_word[23:16] :
                          (byte_reg == 2'h1)    ? src_word[15:8] :
                                                  src_word[7:0];
  wire        bits_done = (bit_reg == tebis_pkg::BIT_LAST);
  wire        last_byte = (byte_reg == tebis_pkg::BYTE_LAST);

  assign tx_active = (state_reg == tebis_pkg::TEBIS_TX) | (state_reg == tebis_pkg::TEBIS_MACK);
  assign pop_req   = (state_reg == tebis_pkg::TEBIS_TX) & scl_fall & bits_done & last_byte & has_pkt_reg;
  assign sda_out   = 1'b0;
  assign sda_oe    = drive_low_reg;

  // Next-state decode of the slave sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tebis_pkg::TEBIS_IDLE: state_next = tebis_pkg::TEBIS_IDLE;
      tebis_pkg::TEBIS_ADDR: begin
        if (scl_fall && ack_reg) begin
          state_next = may_ack ? tebis_pkg::TEBIS_AACK : tebis_pkg::TEBIS_IDLE;
        end
      end
      tebis_pkg::TEBIS_AACK: begin
        if (scl_fall) begin
          state_next = tebis_pkg::TEBIS_TX;
        end
      end
      tebis_pkg::TEBIS_TX: begin
        if (scl_fall && bits_done) begin
          state_next = tebis_pkg::TEBIS_MACK;
        end
      end
      tebis_pkg::TEBIS_MACK: begin
        if (scl_rise) begin
          state_next = sda_s ? tebis_pkg::TEBIS_WAIT : tebis_pkg::TEBIS_MACK;
        end else if (scl_fall) begin
          state_next = tebis_pkg::TEBIS_TX;
        end
      end
      tebis_pkg::TEBIS_WAIT: state_next = tebis_pkg::TEBIS_WAIT;
      default:               state_next = tebis_pkg::TEBIS_IDLE;
    endcase
    if (stop_c) begin
      state_next = tebis_pkg::TEBIS_IDLE;
    end else if (start_c) begin
      state_next = tebis_pkg::TEBIS_ADDR;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= tebis_pkg::TEBIS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Address shift-in, byte shift-out and packet byte position
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sr_reg        <= 8'h00;
      bit_reg       <= 3'h0;
      byte_reg      <= 2'h0;
      word_reg      <= 24'h000000;
      has_pkt_reg   <= 1'b0;
      ack_reg       <= 1'b0;
      drive_low_reg <= 1'b0;
    end else if (start_c || stop_c) begin
      bit_reg       <= 3'h0;
      byte_reg      <= 2'h0;
      ack_reg       <= 1'b0;
      drive_low_reg <= 1'b0;
    end else begin
      case (state_reg)
        tebis_pkg::TEBIS_ADDR: begin
          if (scl_rise) begin
            sr_reg  <= {sr_reg[6:0], sda_s};
            bit_reg <= bit_reg + 3'h1;
            ack_reg <= bits_done;
          end else if (scl_fall && ack_reg) begin
            drive_low_reg <= may_ack;
            ack_reg       <= 1'b0;
          end
        end
        tebis_pkg::TEBIS_AACK, tebis_pkg::TEBIS_MACK: begin
          if (scl_fall && state_next == tebis_pkg::TEBIS_TX) begin
            sr_reg        <= {tx_byte[6:0], 1'b0};
            drive_low_reg <= !tx_byte[7];
            bit_reg       <= 3'h0;
            if (load_new) begin
              word_reg    <= mif.rd_data;
              has_pkt_reg <= !q_empty;
            end
          end
        end
        tebis_pkg::TEBIS_TX: begin
          if (scl_fall) begin
            if (bits_done) begin
              drive_low_reg <= 1'b0;
              byte_reg      <= last_byte ? 2'h0 : byte_reg + 2'h1;
            end else begin
              drive_low_reg <= !sr_reg[7];
              sr_reg        <= {sr_reg[6:0], 1'b0};
              bit_reg       <= bit_reg + 3'h1;
            end
          end
        end
        default: begin
          drive_low_reg <= 1'b0;
        end
      endcase
    end
  end
endmodule : tebis_top

// ===== tebis_asserts.sv
// Checker for the touch event queue: interrupt, pop timing and SDA drive.
// Assumes binding to tebis_top with one clk_sys domain.
`timescale 1ns/1ps
module tebis_asserts (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        operational,
  input wire logic        sample_tick,
  input wire logic [11:0] touch_evt,
  input wire logic        slider_rel,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_oe,
  input wire logic        event_int_n,
  input wire logic        stay_active,
  input wire logic        overflow
);
  logic [4:0] tick_age_reg;
  logic [4:0] fall_age_reg;
  logic [5:0] falls_reg;
  logic       scl_q_reg;
  logic       sda_q_reg;
  wire        scl_fall = scl_q_reg && !scl_in;
  wire        start_c  = scl_in && scl_q_reg && sda_q_reg && !sda_in;
  // Ages since tick and SCL fall, SCL falls since START; all saturate
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tick_age_reg <= 5'h1F;
      fall_age_reg <= 5'h1F;
      falls_reg    <= 6'h00;
      scl_q_reg    <= 1'b1;
      sda_q_reg    <= 1'b1;
    end else begin
      scl_q_reg    <= scl_in;
      sda_q_reg    <= sda_in;
      tick_age_reg <= sample_tick ? 5'h00 : tick_age_reg + {4'h0, tick_age_reg != 5'h1F};
      fall_age_reg <= scl_fall ? 5'h00 : fall_age_reg + {4'h0, fall_age_reg != 5'h1F};
      falls_reg    <= start_c ? 6'h00 : falls_reg + {5'h00, scl_fall && falls_reg != 6'h3F};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_int_stay; event_int_n == !stay_active; endproperty
  a_int_stay: assert property (p_int_stay) else $error("stay_active disagrees with interrupt");
  property p_tick_int; sample_tick && (touch_evt != 12'h000 || slider_rel) |-> ##[1:5] !event_int_n; endproperty
  a_tick_int: assert property (p_tick_int) else $error("interrupt missing after events");
  property p_fall_tick; $fell(event_int_n) |-> tick_age_reg <= 5'h06; endproperty
  a_fall_tick: assert property (p_fall_tick) else $error("interrupt without a sample tick");
  property p_rise_pop; $rose(event_int_n) |-> fall_age_reg <= 5'h0A; endproperty
  a_rise_pop: assert property (p_rise_pop) else $error("interrupt released away from a read");
  property p_pop_byte3; $rose(event_int_n) |-> falls_reg >= 6'h24; endproperty
  a_pop_byte3: assert property (p_pop_byte3) else $error("queue emptied before a third byte");
  property p_ovf_int; overflow |-> !event_int_n && tick_age_reg <= 5'h0F; endproperty
  a_ovf_int: assert property (p_ovf_int) else $error("overflow outside a fill burst");
  property p_nack_empty; (operational && event_int_n) [*8] |-> !sda_oe; endproperty
  a_nack_empty: assert property (p_nack_empty) else $error("SDA driven while queue empty");
  property p_sda_edge; $changed(sda_oe) |-> fall_age_reg <= 5'h07; endproperty
  a_sda_edge: assert property (p_sda_edge) else $error("SDA changed away from SCL fall");
  c_ovf: cover property (overflow);
  c_drain: cover property ($rose(event_int_n));
  c_drive: cover property ($rose(sda_oe));
endmodule : tebis_asserts

bind tebis_top tebis_asserts i_chk (.clk_sys(clk_sys), .nrst(nrst), .operational(operational),
  .sample_tick(sample_tick), .touch_evt(touch_evt), .slider_rel(slider_rel), .scl_in(scl_in),
  .sda_in(sda_in), .sda_oe(sda_oe), .event_int_n(event_int_n), .stay_active(stay_active), .overflow(overflow));

// ===== tebis_host_model.sv
// I2C master standing in for the host that drains the event queue.
// Assumes the bench resolves SDA as open drain with a pull-up.
`timescale 1ns/1ps
module tebis_host_model (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // SCL idles high between frames
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  // One 160 ns bit: SDA moves mid-low, sampled mid-high
  task automatic bit_x(input logic b, output logic r);
    #40 sda_pull = !b;
    #40 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
  endtask : bit_x
  // START, address byte, n data bytes (ACK all but last), STOP
  task automatic xfer(input logic [7:0] a, input int n, output logic ack, output logic [7:0] q [$]);
    logic       r;
    logic [7:0] b;
    q = {};
    #40 sda_pull = 1'b1;
    #40 scl = 1'b0;
    for (int i = 7; i >= 0; i--) bit_x(a[i], r);
    bit_x(1'b1, r);
    ack = !r;
    for (int k = 0; k < n && ack; k++) begin
      for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
      q.push_back(b);
      bit_x(k == n - 1, r);
    end
    #40 sda_pull = 1'b1;
    #40 scl = 1'b1;
    #40 sda_pull = 1'b0;
    #80;
  endtask : xfer
endmodule : tebis_host_model

// ===== tb_top.sv
// Self-checking bench for the touch event queue and its I2C read port.
// Assumes the design, host model and bound checker are compiled first.
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys     = 1'b0;
  logic        nrst        = 1'b0;
  logic [6:0]  slave_addr  = 7'h2A;
  logic        operational = 1'b1;
  logic        sample_tick = 1'b0;
  logic [11:0] touch_evt   = 12'h000;
  logic [11:0] release_evt = 12'h000;
  logic        slider_evt  = 1'b0;
  logic [15:0] slider_pos  = 16'h0000;
  logic        slider_rel  = 1'b0;
  logic        scl, sda_pull, sda_out, sda_oe, event_int_n, stay_active, overflow;
  wire         sda = !(sda_pull || (sda_oe && !sda_out));
  int          failures    = 0;
  int          num_checks  = 0;
  int          ovf_seen    = 0;
  int          ovf_exp     = 0;
  logic [23:0] mq [$];
  logic [3:0]  cnt         = 4'h0;

  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (overflow === 1'b1) ovf_seen++;

  tebis_top i_dut (.clk_sys(clk_sys), .nrst(nrst), .slave_addr(slave_addr), .operational(operational),
    .sample_tick(sample_tick), .touch_evt(touch_evt), .release_evt(release_evt), .slider_evt(slider_evt),
    .slider_pos(slider_pos), .slider_rel(slider_rel), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .event_int_n(event_int_n), .stay_active(stay_active), .overflow(overflow));
  tebis_host_model i_host (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Reference queue push: oldest dropped when full, counter wraps
  task automatic mpush(input logic [3:0] typ, input logic [15:0] d);
    if (mq.size() == tebis_pkg::QUEUE_DEPTH) begin
      mq.delete(0);
      ovf_exp++;
    end
    mq.push_back({cnt, typ, d});
    cnt = cnt + 4'h1;
  endtask : mpush
  task automatic do_reset();
    @(posedge clk_sys);
    nrst       <= 1'b0;
    slave_addr <= 7'($urandom);
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    mq   = {};
    cnt  = 4'h0;
    repeat (3) @(posedge clk_sys);
    check("event_int_n idle", 1'b1, event_int_n);
  endtask : do_reset
  // One sample period; the reference takes at most 12 packets in fixed order
  task automatic tick(input logic [11:0] t, input logic [11:0] r, input logic se, input logic [15:0] p,
                      input logic sr);
    int n;
    n = 0;
    @(posedge clk_sys);
    touch_evt   <= t;
    release_evt <= r;
    slider_evt  <= se;
    slider_pos  <= p;
    slider_rel  <= sr;
    sample_tick <= 1'b1;
    @(posedge clk_sys);
    sample_tick <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      if ((i < 12 ? t[i % 12] : r[i % 12]) && n < 12) begin
        mpush(i < 12 ? tebis_pkg::TYPE_TOUCH : tebis_pkg::TYPE_RELEASE, {8'(i % 12), 8'h00});
        n++;
      end
    end
    if (se && n < 12) mpush(tebis_pkg::TYPE_SLIDER, p);
    if (se && n < 12) n++;
    if (sr && n < 12) mpush(tebis_pkg::TYPE_SLIDER, tebis_pkg::SLIDER_RELEASED);
    repeat (16) @(posedge clk_sys);
  endtask : tick
  // One read (or write when rw low) of n bytes, compared with the reference
  task automatic rd(input logic [6:0] a, input logic rw, input int n);
    logic       ack;
    logic       exp_ack;
    logic [7:0] q [$];
    @(posedge clk_sys);
    #3; // Link edges stay clear of clk_sys edges
    exp_ack = rw && a == slave_addr && (mq.size() > 0 || !operational);
    i_host.xfer({a, rw}, n, ack, q);
    check("address ack", exp_ack, ack);
    check("byte count", ack ? n : 0, q.size());
    for (int k = 0; k < q.size(); k++)
      check("read byte", k / 3 < mq.size() ? mq[k / 3][23 - 8 * (k % 3) -: 8] : 8'hFF, q[k]);
    if (ack) repeat (n / 3) if (mq.size() > 0) mq.delete(0);
    check("event_int_n", mq.size() == 0, event_int_n);
    check("stay_active", mq.size() != 0, stay_active);
  endtask : rd
  task automatic close_out();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  // Watchdog against a hung run
  initial begin
    #2000000;
    failures++;
    close_out();
  end
  initial begin
    void'($urandom(89));
    do_reset();
    rd(slave_addr, 1'b1, 3);
    tick(12'h005, 12'h000, 1'b0, 16'h0000, 1'b0);
    rd(slave_addr, 1'b1, 1);
    rd(slave_addr, 1'b1, 2);
    rd(slave_addr, 1'b0, 0);
    rd(slave_addr ^ 7'h01, 1'b1, 3);
    rd(slave_addr, 1'b1, 6);
    tick(12'h800, 12'h001, 1'b1, 16'hFFFE, 1'b1);
    tick(12'h000, 12'h000, 1'b1, 16'h0000, 1'b0);
    rd(slave_addr, 1'b1, 9);
    rd(slave_addr, 1'b1, 9);
    tick(12'hFFF, 12'hFFF, 1'b1, 16'h1234, 1'b1);
    for (int p = 0; p < 4; p++)
      tick(12'($urandom), 12'($urandom), 1'($urandom), 16'($urandom_range(32'h0000FFFE)), 1'($urandom));
    repeat (24) if (mq.size() > 0) rd(slave_addr, 1'b1, 3);
    @(posedge clk_sys);
    operational <= 1'b0;
    rd(slave_addr, 1'b1, 3);
    @(posedge clk_sys);
    operational <= 1'b1;
    tick(12'h010, 12'h000, 1'b0, 16'h0000, 1'b0);
    do_reset();
    rd(slave_addr, 1'b1, 3);
    tick(12'h000, 12'h400, 1'b0, 16'h0000, 1'b0);
    rd(slave_addr, 1'b1, 3);
    check("overflow pulses", ovf_exp, ovf_seen);
    close_out();
  end
endmodule : tb_top
